// ### tol_limit_regs.sv
// Purpose: limit and response registers
// Assumes: telemetry on clock_i in whole degrees and quarter volts
// Notes: fault response only drives shutdown and latch-off; power stage lies outside
`timescale 1ns/1ns
`default_nettype none
module tol_limit_regs #(
   parameter logic [6:0] PMB_ADDR = 7'h24,
   parameter int TON_RISE_CYCLES =
      tol_pkg::TON_RISE_US * (tol_pkg::CLK_HZ / 1_000_000)
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic alert_o,
   output logic alert_oe_n_o,
   input wire logic signed [15:0] temperature_i,
   input wire logic [15:0] vin_q4_i,
   input wire logic telem_update_i,
   input wire logic pwm_clk_en_i,
   input wire logic enable_i,
   input wire logic signed [15:0] ot_fault_limit_i,
   input wire logic [7:0] nvm_warn_deg_i,
   input wire logic [6:0] nvm_vin_q4_i,
   input wire logic [7:0] nvm_resp_i,
   input wire logic nvm_sync_i,
   output logic overheat_warning_flag_o,
   output logic input_overvoltage_flag_o,
   output logic shutdown_o,
   output logic latched_off_o,
   output logic signed [15:0] ot_release_deg_o
);
   import tol_pkg::*;
   tol_wr_t wr;
   logic [7:0] rd_cmd;
   logic [15:0] rd_data;
   logic [15:0] warn_q;
   logic [15:0] vinl_q;
   logic [7:0] resp_q;
   logic loaded_q;
   logic [7:0] sb_q;
   logic sw_input_q;
   logic st_otw_q;
   logic si_vinov_q;
   logic [1:0] cml_q;
   logic clear;
   logic bad_cmd;
   logic bad_data;
   logic signed [31:0] warn_q4;
   logic signed [31:0] vinl_q4;
   logic signed [31:0] wr_q4;
   logic signed [31:0] temp_q4;
   logic signed [15:0] warn_deg;
   logic warn_off;
   tol_fault_st_t fst_q;
   logic [3:0] pwm_cnt_q;
   logic [31:0] hic_cnt_q;
   logic [2:0] tries_q;

   // whole degree, nearest, clamped into the nvm options
   function automatic logic [10:0] round_deg(input logic signed [31:0] q);
      logic signed [31:0] d;
      d = (q + 32'sd2) >>> 2;
      if (q == OTW_OFF_Q4)
         return 11'(OTW_OFF_DEG);
      if (d < 0)
         return 11'h000;
      if (d > 32'(OTW_MAX_DEG))
         return 11'(OTW_MAX_DEG);
      return d[10:0];
   endfunction : round_deg

   function automatic logic [10:0] clamp_vin(input logic signed [31:0] q);
      if (q < VIN_MIN_Q4)
         return 11'(VIN_MIN_Q4);
      if (q > VIN_MAX_Q4)
         return 11'(VIN_MAX_Q4);
      return q[10:0];
   endfunction : clamp_vin

   function automatic logic [3:0] dly_pwm(input logic [2:0] c);
      if (c < 3'h2)
         return DLY_SHORT_PWM;
      if (c < 3'h5)
         return DLY_MID_PWM;
      return DLY_LONG_PWM;
   endfunction : dly_pwm

   tol_pmbus_slave #(
      .ADDR(PMB_ADDR)
   ) u_bus (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_n_o(sda_oe_n_o),
      .wr_o(wr),
      .rd_cmd_o(rd_cmd),
      .rd_data_i(rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   assign warn_q4 = tol_to_q4(warn_q);
   assign vinl_q4 = tol_to_q4(vinl_q);
   assign wr_q4 = tol_to_q4(wr.data);
   assign temp_q4 = {{14{temperature_i[15]}}, temperature_i, 2'h0};
   assign warn_off = (warn_q4 == OTW_OFF_Q4);
   assign warn_deg = 16'(round_deg(warn_q4));
   assign clear = wr.stb && wr.cmd == CMD_CLEAR_FAULTS && wr.nbytes == 2'h0;

   always_comb
   begin
      bad_cmd = 1'b0;
      bad_data = 1'b0;
      if (wr.stb)
      begin
         case (wr.cmd)
            CMD_CLEAR_FAULTS: bad_data = (wr.nbytes != 2'h0);
            CMD_OT_WARN: bad_data = (wr.nbytes != 2'h2) ||
               !((wr_q4 >= OTW_MIN_Q4 && wr_q4 <= OTW_MAX_Q4) ||
                 wr_q4 == OTW_OFF_Q4);
            CMD_INPUT_OVERVOLTAGE_FLAG: bad_data = (wr.nbytes != 2'h2) ||
               wr_q4 < VIN_MIN_Q4 || wr_q4 > VIN_MAX_Q4;
            CMD_VIN_RESP: bad_data = (wr.nbytes != 2'h1) ||
               wr.data[ACT_LSB +: 2] == ACT_BAD;
            default: bad_cmd = 1'b1;
         endcase
      end
   end

   always_comb
   begin
      case (rd_cmd)
         CMD_OT_WARN: rd_data = warn_q;
         CMD_INPUT_OVERVOLTAGE_FLAG: rd_data = vinl_q;
         CMD_VIN_RESP: rd_data = {8'h00, resp_q};
         CMD_STATUS_BYTE: rd_data = {8'h00, sb_q};
         CMD_STATUS_WORD: rd_data = {2'h0, sw_input_q, 5'h00, sb_q};
         CMD_STATUS_TEMP: rd_data = {8'h00, 1'b0, st_otw_q, 6'h00};
         CMD_STATUS_INPUT: rd_data = {8'h00, si_vinov_q, 7'h00};
         CMD_STATUS_CML: rd_data = {8'h00, cml_q, 6'h00};
         default: rd_data = 16'hffff;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // nvm image is loaded once after reset release, never under reset
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         warn_q <= OTW_WORD_RST;
         vinl_q <= VIN_WORD_RST;
         resp_q <= RESP_RST;
         loaded_q <= 1'b0;
      end
      else
      begin
         loaded_q <= 1'b1;
         if (!loaded_q)
         begin
            warn_q <= {WARN_LIMIT_EXPONENT_NVM, round_deg({22'h0, nvm_warn_deg_i, 2'h0})};
            vinl_q <= {VIN_EXP_NVM, clamp_vin({25'h0, nvm_vin_q4_i})};
            if (nvm_resp_i[ACT_LSB +: 2] != ACT_BAD)
               resp_q <= nvm_resp_i;
         end
         else if (nvm_sync_i)
         begin
            warn_q <= {WARN_LIMIT_EXPONENT_NVM, round_deg(warn_q4)};
            vinl_q <= {VIN_EXP_NVM, clamp_vin(vinl_q4)};
         end
         else if (wr.stb && !bad_data)
         begin
            if (wr.cmd == CMD_OT_WARN)
               warn_q <= wr.data;
            if (wr.cmd == CMD_INPUT_OVERVOLTAGE_FLAG)
               vinl_q <= wr.data;
            if (wr.cmd == CMD_VIN_RESP)
               resp_q <= wr.data[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         overheat_warning_flag_o <= 1'b0;
         input_overvoltage_flag_o <= 1'b0;
         ot_release_deg_o <= 16'sh0000;
      end
      else
      begin
         if (telem_update_i)
         begin
            overheat_warning_flag_o <= !warn_off &&
               temp_q4 >= warn_q4;
            input_overvoltage_flag_o <= {16'h0, vin_q4_i} >= vinl_q4;
         end
         if (warn_off || warn_deg > ot_fault_limit_i)
            ot_release_deg_o <= ot_fault_limit_i - OT_HYST_DEG;
         else
            ot_release_deg_o <= warn_deg;
      end
   end

   // sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sb_q <= 8'h00;
         sw_input_q <= 1'b0;
         st_otw_q <= 1'b0;
         si_vinov_q <= 1'b0;
         cml_q <= 2'h0;
         alert_oe_n_o <= 1'b1;
         alert_o <= 1'b0;
         sda_o <= 1'b0;
      end
      else
      begin
         if (clear)
         begin
            sb_q <= 8'h00;
            sw_input_q <= 1'b0;
            st_otw_q <= 1'b0;
            si_vinov_q <= 1'b0;
            cml_q <= 2'h0;
         end
         if (overheat_warning_flag_o)
         begin
            sb_q[SB_TEMP] <= 1'b1;
            st_otw_q <= 1'b1;
         end
         if (input_overvoltage_flag_o)
         begin
            sb_q[SB_NOTA] <= 1'b1;
            sw_input_q <= 1'b1;
            si_vinov_q <= 1'b1;
         end
         if (bad_cmd || bad_data)
         begin
            sb_q[SB_CML] <= 1'b1;
            cml_q <= cml_q | {bad_cmd, bad_data};
         end
         // alert pin pulls low while any status bit stands
         alert_oe_n_o <= !(|sb_q || sw_input_q);
         alert_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fst_q <= F_RUN;
         pwm_cnt_q <= 4'h0;
         hic_cnt_q <= 32'h0;
         tries_q <= 3'h0;
         shutdown_o <= 1'b0;
         latched_off_o <= 1'b0;
      end
      else if (!enable_i)
      begin
         // commanded off ends retries and latch-off
         fst_q <= F_RUN;
         tries_q <= 3'h0;
         shutdown_o <= 1'b0;
         latched_off_o <= 1'b0;
      end
      else
      begin
         case (fst_q)
            F_RUN:
            begin
               pwm_cnt_q <= 4'h0;
               hic_cnt_q <= 32'h0;
               if (input_overvoltage_flag_o)
               begin
                  if (resp_q[ACT_LSB +: 2] == ACT_DELAYED)
                     fst_q <= F_DELAY;
                  else if (resp_q[ACT_LSB +: 2] == ACT_IMMED)
                  begin
                     fst_q <= F_HICCUP;
                     shutdown_o <= 1'b1;
                  end
               end
            end
            F_DELAY:
            begin
               if (!input_overvoltage_flag_o)
                  fst_q <= F_RUN;
               else if (pwm_cnt_q == dly_pwm(resp_q[DLY_LSB +: 3]))
               begin
                  fst_q <= F_HICCUP;
                  shutdown_o <= 1'b1;
               end
               else if (pwm_clk_en_i)
                  pwm_cnt_q <= pwm_cnt_q + 4'h1;
            end
            F_HICCUP:
            begin
               hic_cnt_q <= hic_cnt_q + 32'h1;
               if (resp_q[RETRY_LSB +: 3] == RETRY_NONE ||
                   (resp_q[RETRY_LSB +: 3] != RETRY_FOREVER &&
                    tries_q >= resp_q[RETRY_LSB +: 3]))
               begin
                  fst_q <= F_LATCH;
                  latched_off_o <= 1'b1;
               end
               else if (hic_cnt_q >= 32'(TON_RISE_CYCLES) *
                        ((resp_q[DLY_LSB +: 3] < 3'h2) ? 32'h1 :
                         {29'h0, resp_q[DLY_LSB +: 3]}) - 32'h1)
               begin
                  fst_q <= F_RUN;
                  shutdown_o <= 1'b0;
                  if (tries_q != RETRY_FOREVER)
                     tries_q <= tries_q + 3'h1;
               end
            end
            F_LATCH:
            begin
               shutdown_o <= 1'b1;
            end
            default:
            begin
               fst_q <= F_RUN;
            end
         endcase
      end
   end
endmodule : tol_limit_regs
`default_nettype wire

// ### tol_limit_regs_monitor.sv
// Purpose: port checks
// Assumes: ot_fault_limit_i is held steady by the bench
// Notes: flags may only move after a telemetry pulse
`timescale 1ns/1ns
`default_nettype none
module tol_limit_regs_monitor (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic alert_oe_n_o,
   input wire logic telem_update_i,
   input wire logic enable_i,
   input wire logic signed [15:0] ot_fault_limit_i,
   input wire logic overheat_warning_flag_o,
   input wire logic input_overvoltage_flag_o,
   input wire logic shutdown_o,
   input wire logic latched_off_o,
   input wire logic signed [15:0] ot_release_deg_o
);
   default clocking mon_cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   warn_alert_a: assert property (overheat_warning_flag_o
      |-> ##[1:2] !alert_oe_n_o) else $error("warning gave no alert");
   ov_alert_a: assert property (input_overvoltage_flag_o
      |-> ##[1:2] !alert_oe_n_o) else $error("fault gave no alert");
   warn_move_a: assert property ($changed(overheat_warning_flag_o)
      |-> $past(telem_update_i)) else $error("warning moved alone");
   ov_move_a: assert property ($changed(input_overvoltage_flag_o)
      |-> $past(telem_update_i)) else $error("fault moved alone");
   release_cap_a: assert property (ot_release_deg_o
      <= ot_fault_limit_i) else $error("release above fault");
   shut_cause_a: assert property ($rose(shutdown_o)
      |-> $past(input_overvoltage_flag_o)) else $error("shutdown uncaused");
   latch_cause_a: assert property ($rose(latched_off_o)
      |-> $past(shutdown_o)) else $error("latch without shutdown");
   off_clear_a: assert property (!enable_i
      |=> !shutdown_o && !latched_off_o) else $error("off kept state");
endmodule : tol_limit_regs_monitor
bind tol_limit_regs tol_limit_regs_monitor mon_u (.*);
`default_nettype wire

// ### tol_limit_regs_test.sv
// Purpose: self-checking run
// Assumes: fault limit 110 C
// Notes: reads queued, checked on landing
`timescale 1ns/1ns
`default_nettype none
module tol_limit_regs_test;
   import tol_pkg::*;
   logic clock_i = 1'b0, rst_i, scl_i, sda_h, sda_o, sda_oe_n_o;
   logic alert_o, alert_oe_n_o, rd_stb, overheat_warning_flag_o;
   logic input_overvoltage_flag_o, shutdown_o, latched_off_o;
   logic telem_update_i, pwm_clk_en_i, enable_i, nvm_sync_i;
   logic signed [15:0] temperature_i, ot_release_deg_o, ot_fault_limit_i;
   logic [15:0] vin_q4_i, rd_word, exp_q[$];
   logic [7:0] nvm_warn_deg_i, nvm_resp_i;
   logic [6:0] nvm_vin_q4_i, q;
   int errors = 0, n_compared = 0;
   wire logic sda_i;
   assign sda_i = sda_h & (sda_oe_n_o | sda_o);
   always #50 clock_i = ~clock_i;
   tol_limit_regs #(.TON_RISE_CYCLES(20)) dut_u (.clock_i, .rst_i, .scl_i,
      .sda_i, .sda_o, .sda_oe_n_o, .alert_o, .alert_oe_n_o, .temperature_i,
      .vin_q4_i, .telem_update_i, .pwm_clk_en_i, .enable_i, .ot_fault_limit_i,
      .nvm_warn_deg_i, .nvm_vin_q4_i, .nvm_resp_i, .nvm_sync_i,
      .overheat_warning_flag_o, .input_overvoltage_flag_o, .shutdown_o,
      .latched_off_o, .ot_release_deg_o);
   tol_pmbus_host host_u (.clock_i, .sda_i, .scl_o(scl_i), .sda_o(sda_h),
      .rd_stb_o(rd_stb), .rd_word_o(rd_word));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic rx(input logic [7:0] c, input int n, input logic [15:0] e);
      exp_q.push_back(e);
      host_u.rd(c, n);
      host_u.hold(1);
   endtask : rx
   task automatic tick(input logic signed [15:0] t, input logic [15:0] v);
      temperature_i <= t;
      vin_q4_i <= v;
      telem_update_i <= 1'b1;
      host_u.hold(1);
      telem_update_i <= 1'b0;
      host_u.hold(3);
   endtask : tick
   task automatic pwm(input int n);
      repeat (n)
      begin
         pwm_clk_en_i <= 1'b1;
         host_u.hold(1);
         pwm_clk_en_i <= 1'b0;
         host_u.hold(1);
      end
   endtask : pwm
   always @(posedge clock_i)
      if (rd_stb) chk("read", exp_q.pop_front(), rd_word);
   initial
   begin
      host_u.hold(90000);
      errors++;
      summarize();
   end
   initial
   begin
      void'($urandom(77));
      {rst_i, telem_update_i, pwm_clk_en_i, enable_i, nvm_sync_i} <= 5'h12;
      {temperature_i, vin_q4_i, ot_fault_limit_i} <= {16'h0, 16'h10, 16'd110};
      {nvm_vin_q4_i, nvm_resp_i} <= {7'h30, 8'h13};
      nvm_warn_deg_i <= 8'h50 + 8'($urandom_range(15));
      host_u.hold(3);
      rst_i <= 1'b0;
      host_u.hold(4);
      rx(CMD_OT_WARN, 2, {8'h00, nvm_warn_deg_i});
      rx(CMD_INPUT_OVERVOLTAGE_FLAG, 2, 16'hf030);
      rx(CMD_VIN_RESP, 1, 16'h0013);
      q = 7'(20 + $urandom_range(68));
      host_u.wr(CMD_INPUT_OVERVOLTAGE_FLAG, {5'h1e, 4'h0, q}, 2);
      host_u.wr(CMD_INPUT_OVERVOLTAGE_FLAG, 16'hf059, 2);
      rx(CMD_INPUT_OVERVOLTAGE_FLAG, 2, {5'h1e, 4'h0, q});
      host_u.wr(CMD_OT_WARN, 16'h00a1, 2);
      rx(CMD_OT_WARN, 2, {8'h00, nvm_warn_deg_i});
      host_u.wr(8'h20, 16'h0, 1);
      host_u.wr(CMD_VIN_RESP, 16'h00c0, 1);
      rx(CMD_VIN_RESP, 1, 16'h0013);
      rx(CMD_STATUS_CML, 1, 16'h00c0);
      chk("alert", 16'h0, alert_oe_n_o);
      host_u.wr(CMD_OT_WARN, 16'h0064, 2);
      tick(100, 16);
      chk("warn", 16'h1, overheat_warning_flag_o);
      chk("release", 16'd100, ot_release_deg_o);
      rx(CMD_STATUS_TEMP, 1, 16'h0040);
      tick(99, 16);
      chk("warn", 16'h0, overheat_warning_flag_o);
      host_u.wr(CMD_OT_WARN, 16'h00ff, 2);
      tick(120, 16);
      chk("warn", 16'h0, overheat_warning_flag_o);
      chk("release", 16'd90, ot_release_deg_o);
      host_u.wr(CMD_OT_WARN, 16'hf8c9, 2);
      nvm_sync_i <= 1'b1;
      host_u.hold(1);
      nvm_sync_i <= 1'b0;
      rx(CMD_OT_WARN, 2, 16'h0065);
      tick(20, 16);
      host_u.wr(CMD_CLEAR_FAULTS, 16'h0, 0);
      host_u.wr(CMD_VIN_RESP, 16'h0042, 1);
      tick(20, 90);
      chk("ov", 16'h1, input_overvoltage_flag_o);
      pwm(4);
      chk("shutdown", 16'h0, shutdown_o);
      pwm(1);
      host_u.hold(3);
      chk("shutdown", 16'h1, shutdown_o);
      chk("latched", 16'h1, latched_off_o);
      rx(CMD_STATUS_INPUT, 1, 16'h0080);
      rx(CMD_STATUS_WORD, 2, 16'h2001);
      enable_i <= 1'b0;
      host_u.hold(2);
      chk("latched", 16'h0, latched_off_o);
      host_u.wr(CMD_VIN_RESP, 16'h0080, 1);
      enable_i <= 1'b1;
      host_u.hold(3);
      chk("shutdown", 16'h1, shutdown_o);
      summarize();
   end
endmodule : tol_limit_regs_test
`default_nettype wire

// ### tol_pkg.sv
// Purpose: shared constants and types
// Assumes: one 10 MHz clock
// Notes: status codes chosen here
// Function
// - warning limit word at 51h, degrees
// - warning trip sets status bits, alerts
// - warning exponent resets to zero, mantissa nvm
// - bad warning write flags cml, alerts
// - store/restore rounds warning to 0..160
// - warning of 255 degrees disables it
// - warning is fault release, else 20 hysteresis
// - ov limit word at 55h, fault at limit
// - ov exponent resets to 11110b, mantissa nvm
// - ov limits 5 V to 22 V, 0.25 V steps
// - out of range ov write flags cml, alerts
// - store/restore rounds ov limit to a step
// - ov fault sets three status bits, alerts
// - response byte at 56h, nvm backed, at once
// - action 7:6: ignore, delayed, immediate, 11 bad
// - retry 5:3: 0 latch, 1..6 retries, 7 forever
// - delay 2:0: 3, 5 or 9 pwm clocks; hiccup
package tol_pkg;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OT_WARN = 8'h51;
   localparam logic [7:0] CMD_INPUT_OVERVOLTAGE_FLAG = 8'h55;
   localparam logic [7:0] CMD_VIN_RESP = 8'h56;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
   localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
   localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
   localparam logic [15:0] OTW_WORD_RST = 16'h0000;
   localparam logic [15:0] VIN_WORD_RST = 16'hf000;
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam logic [4:0] WARN_LIMIT_EXPONENT_NVM = 5'h00;
   localparam logic [4:0] VIN_EXP_NVM = 5'h1e;
   localparam int EXP_LSB = 11;
   localparam int ACT_LSB = 6;
   localparam int RETRY_LSB = 3;
   localparam int DLY_LSB = 0;
   localparam logic signed [31:0] OTW_MIN_Q4 = 32'sd0;
   localparam logic signed [31:0] OTW_MAX_Q4 = 32'sd640;
   localparam logic signed [31:0] OTW_OFF_Q4 = 32'sd1020;
   localparam logic signed [31:0] VIN_MIN_Q4 = 32'sd20;
   localparam logic signed [31:0] VIN_MAX_Q4 = 32'sd88;
   localparam logic signed [15:0] OTW_MAX_DEG = 16'sd160;
   localparam logic signed [15:0] OTW_OFF_DEG = 16'sd255;
   localparam logic signed [15:0] OT_HYST_DEG = 16'sd20;
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_DELAYED = 2'h1;
   localparam logic [1:0] ACT_IMMED = 2'h2;
   localparam logic [1:0] ACT_BAD = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   localparam logic [3:0] DLY_SHORT_PWM = 4'h3;
   localparam logic [3:0] DLY_MID_PWM = 4'h5;
   localparam logic [3:0] DLY_LONG_PWM = 4'h9;
   localparam int SB_NOTA = 0;
   localparam int SB_CML = 1;
   localparam int SB_TEMP = 2;
   localparam int SW_INPUT = 13;
   localparam int ST_OTW = 6;
   localparam int SI_VINOV = 7;
   localparam int CML_CMD = 7;
   localparam int CML_DATA = 6;
   localparam int CLK_HZ = 10_000_000;
   localparam int TON_RISE_US = 1000;

   typedef struct packed {
      logic stb;
      logic [7:0] cmd;
      logic [15:0] data;
      logic [1:0] nbytes;
   } tol_wr_t;

   typedef enum {F_RUN, F_DELAY, F_HICCUP, F_LATCH} tol_fault_st_t;

   // slinear11 to quarter units, half rounding up when bits fall off
   function automatic logic signed [31:0] tol_to_q4(input logic [15:0] w);
      logic signed [31:0] m;
      logic signed [31:0] s;
      logic [4:0] n;
      m = {{21{w[10]}}, w[10:0]};
      s = {{27{w[15]}}, w[15:11]} + 32'sd2;
      n = 5'h00;
      if (s >= 0)
      begin
         n = (s > 32'sd16) ? 5'h10 : s[4:0];
         return m <<< n;
      end
      n = 5'(-s);
      return (m + (32'sd1 <<< (n - 5'h01))) >>> n;
   endfunction : tol_to_q4
endpackage : tol_pkg

// ### tol_pmbus_host.sv
// Purpose: pmbus host model
// Assumes: 8 clocks per scl period, 4 low and 4 high
// Notes: scl stands high between frames; reads low byte first
`timescale 1ns/1ns
`default_nettype none
module tol_pmbus_host (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic rd_stb_o,
   output logic [15:0] rd_word_o
);
   logic [31:0] sh = 32'h0;
   initial scl_o = 1'b1;
   initial sda_o = 1'b1;
   initial rd_stb_o = 1'b0;
   initial rd_word_o = 16'h0;
   task automatic hold(input int n);
      repeat (n) @(posedge clock_i);
   endtask : hold
   // data moves only while scl is low
   task automatic bit_io(input logic v);
      sda_o <= v;
      hold(2);
      scl_o <= 1'b1;
      hold(4);
      sh = {sh[30:0], sda_i};
      scl_o <= 1'b0;
      hold(2);
   endtask : bit_io
   task automatic edge_pair(input logic a);
      sda_o <= a;
      hold(2);
      scl_o <= 1'b1;
      hold(4);
      sda_o <= ~a;
      hold(4);
   endtask : edge_pair
   task automatic put(input logic [7:0] v, input logic a);
      for (int i = 7; i >= 0; i--) bit_io(v[i]);
      bit_io(a);
   endtask : put
   task automatic head(input logic [7:0] c);
      edge_pair(1'b1);
      scl_o <= 1'b0;
      hold(2);
      put(8'h48, 1'b1);
      put(c, 1'b1);
   endtask : head
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
      head(c);
      if (n > 0) put(d[7:0], 1'b1);
      if (n > 1) put(d[15:8], 1'b1);
      edge_pair(1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] c, input int n);
      head(c);
      edge_pair(1'b1);
      scl_o <= 1'b0;
      hold(2);
      put(8'h49, 1'b1);
      if (n > 1) put(8'hff, 1'b0);
      put(8'hff, 1'b1);
      edge_pair(1'b0);
      rd_word_o <= (n > 1) ? {sh[8:1], sh[17:10]} : {8'h00, sh[8:1]};
      rd_stb_o <= 1'b1;
      hold(1);
      rd_stb_o <= 1'b0;
   endtask : rd
endmodule : tol_pmbus_host
`default_nettype wire

// ### tol_pmbus_slave.sv
// Purpose: smbus byte engine
// Assumes: scl slow against clock_i
// Notes: write is committed at stop so a short frame never half-applies
`timescale 1ns/1ns
`default_nettype none
module tol_pmbus_slave #(
   parameter logic [6:0] ADDR = 7'h24
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_n_o,
   output tol_pkg::tol_wr_t wr_o,
   output logic [7:0] rd_cmd_o,
   input wire logic [15:0] rd_data_i
);
   import tol_pkg::*;
   typedef enum {S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_RACK} tol_bus_st_t;
   tol_bus_st_t st_q;
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic have_cmd_q;
   logic nack_q;
   logic [1:0] nb_q;
   logic [1:0] txi_q;
   logic [15:0] data_q;
   logic start;
   logic stop;
   logic rise;
   logic fall;
   logic [7:0] next_tx;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end
      else
      begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end

   assign start = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
   assign stop = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
   assign rise = scl_q[1] && !scl_q[2];
   assign fall = !scl_q[1] && scl_q[2];
   assign next_tx = (txi_q == 2'h0) ? rd_data_i[7:0] :
                    (txi_q == 2'h1) ? rd_data_i[15:8] : 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         have_cmd_q <= 1'b0;
         nack_q <= 1'b0;
         nb_q <= 2'h0;
         txi_q <= 2'h0;
         data_q <= 16'h0000;
         rd_cmd_o <= 8'h00;
         sda_oe_n_o <= 1'b1;
         wr_o <= '0;
      end
      else
      begin
         wr_o.stb <= 1'b0;
         if (stop)
         begin
            if (have_cmd_q && !rw_q)
            begin
               wr_o <= '{stb: 1'b1, cmd: rd_cmd_o, data: data_q, nbytes: nb_q};
            end
            have_cmd_q <= 1'b0;
            sda_oe_n_o <= 1'b1;
            st_q <= S_IDLE;
         end
         else if (start)
         begin
            // repeated start keeps the command for the read that follows
            st_q <= S_ADDR;
            bit_q <= 4'h0;
            nb_q <= 2'h0;
            txi_q <= 2'h0;
            sda_oe_n_o <= 1'b1;
         end
         else
         begin
            case (st_q)
               S_ADDR, S_RX:
               begin
                  if (rise && bit_q < 4'h8)
                  begin
                     sh_q <= {sh_q[6:0], sda_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end
                  else if (fall && bit_q == 4'h8)
                  begin
                     st_q <= S_ACK;
                     sda_oe_n_o <= 1'b0;
                     if (st_q == S_ADDR)
                     begin
                        rw_q <= sh_q[0];
                        if (sh_q[7:1] != ADDR)
                        begin
                           st_q <= S_IDLE;
                           sda_oe_n_o <= 1'b1;
                        end
                     end
                     else if (!have_cmd_q)
                     begin
                        rd_cmd_o <= sh_q;
                        have_cmd_q <= 1'b1;
                     end
                     else
                     begin
                        if (nb_q == 2'h0)
                           data_q[7:0] <= sh_q;
                        else if (nb_q == 2'h1)
                           data_q[15:8] <= sh_q;
                        if (nb_q != 2'h3)
                           nb_q <= nb_q + 2'h1;
                     end
                  end
               end
               S_ACK:
               begin
                  if (fall)
                  begin
                     bit_q <= 4'h0;
                     sda_oe_n_o <= 1'b1;
                     st_q <= S_RX;
                     if (rw_q)
                     begin
                        st_q <= S_TX;
                        tx_q <= {next_tx[6:0], 1'b1};
                        sda_oe_n_o <= next_tx[7];
                        bit_q <= 4'h1;
                        txi_q <= txi_q + 2'h1;
                     end
                  end
               end
               S_TX:
               begin
                  if (fall)
                  begin
                     if (bit_q < 4'h8)
                     begin
                        sda_oe_n_o <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                     end
                     else
                     begin
                        sda_oe_n_o <= 1'b1;
                        st_q <= S_RACK;
                     end
                  end
               end
               S_RACK:
               begin
                  if (rise)
                     nack_q <= sda_q[1];
                  else if (fall)
                  begin
                     st_q <= S_IDLE;
                     if (!nack_q)
                     begin
                        st_q <= S_TX;
                        tx_q <= {next_tx[6:0], 1'b1};
                        sda_oe_n_o <= next_tx[7];
                        bit_q <= 4'h1;
                        if (txi_q != 2'h3)
                           txi_q <= txi_q + 2'h1;
                     end
                  end
               end
               default:
               begin
                  st_q <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule : tol_pmbus_slave
`default_nettype wire
